// ===== rtl/ashc_edge_det.sv
// edge detector against previous cycle sample
`timescale 1ns/10ps
`default_nettype none
module ashc_edge_det #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk, // clock
  input  wire logic         sys_rst,  // async reset, high
  input  wire logic         ce,       // clock enable
  input  wire logic [W-1:0] d,        // sampled inputs
  output logic      [W-1:0] rise,     // low to high this cycle
  output logic      [W-1:0] fall      // high to low this cycle
);
  logic [W-1:0] prev_reg;

  // previous cycle sample
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else if (ce) begin
      prev_reg <= d;
    end
  end

  // compare with previous sample
  assign rise = d & ~prev_reg;
  assign fall = ~d & prev_reg;
endmodule
`default_nettype wire

// ===== rtl/ashc_offset_store.sv
// retained storage for the absolute encoder offset
`timescale 1ns/10ps
`default_nettype none
module ashc_offset_store (
  input  wire logic                      core_clk, // clock
  input  wire logic                      nv_init,  // first power-up clear
  input  wire logic                      ce,       // clock enable
  input  wire logic                      wr_en,    // store new offset
  input  wire logic [ashc_pkg::POS_W-1:0] wr_data, // offset to store
  output logic      [ashc_pkg::POS_W-1:0] rd_data, // stored offset
  output logic                           rd_valid  // an offset was stored
);
  // cleared only by nv_init, never by controller reset
  always_ff @(posedge core_clk or posedge nv_init) begin
    if (nv_init) begin
      rd_data  <= ashc_pkg::OFFSET_RST;
      rd_valid <= 1'b0;
    end else if (ce && wr_en) begin
      rd_data  <= wr_data;
      rd_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ashc_pkg.sv
// package with constants and carrier types for the axis stop and homing block
//
// Functional notes
// - stop removes all traversing outputs at once
// - no new motion starts while stop held
// - stop outranks every other command input
// - homing starts on request rising edge
// - method: 0 preset, 1/2 passive, 3 absolute
// - methods 0..2 incremental only, 3 absolute only
// - direct preset only with no motion
// - direct preset loads position on request edge
// - success sets homed; repeat keeps it set
// - passive homing startable moving or at rest
// - passive loads on reference event, matching direction
// - arming passive homing never drives the axis
// - reference event from one configured source
// - combined source: zero mark gated by input
// - absolute adjustment only with no motion
// - absolute adjustment needs only the request edge
// - offset equals preset minus encoder position
// - absolute offset kept across power cycles
// - position equals offset plus encoder position
// - incremental homed lost on start or encoder error
// - jog accepted whether homed or not
package ashc_pkg;

  localparam int unsigned POS_W = 32;

  // homing methods
  localparam logic [1:0] METHOD_PRESET   = 2'h0;
  localparam logic [1:0] METHOD_PASS_POS = 2'h1;
  localparam logic [1:0] METHOD_PASS_NEG = 2'h2;
  localparam logic [1:0] METHOD_ABS_ADJ  = 2'h3;

  // reference event sources
  localparam logic [1:0] SRC_ZERO_MARK = 2'h0;
  localparam logic [1:0] SRC_DI_RISE   = 2'h1;
  localparam logic [1:0] SRC_DI_FALL   = 2'h2;
  localparam logic [1:0] SRC_COMBINED  = 2'h3;

  // reset values
  localparam logic [POS_W-1:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_RST    = 32'h0000_0000;

  // edge detector lane positions
  localparam int unsigned EDGE_N    = 4;
  localparam int unsigned LANE_HOME = 0;
  localparam int unsigned LANE_JOGP = 1;
  localparam int unsigned LANE_JOGN = 2;
  localparam int unsigned LANE_DI   = 3;

  // homing sequencer states, gray along idle -> armed
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_ARMED = 2'b01
  } ashc_home_state_t;

  // static configuration of encoder and reference source
  typedef struct packed {
    logic       abs_encoder;   // 1: absolute encoder fitted
    logic [1:0] ref_source;    // reference event source
    logic       di_active_hi;  // active level of reference input
  } ashc_cfg_t;

  // contactor outputs
  typedef struct packed {
    logic pos;    // traverse positive
    logic neg;    // traverse negative
    logic rapid;  // rapid traverse, else creep
  } ashc_drive_t;

  // homing status
  typedef struct packed {
    logic homed;  // axis homed
    logic armed;  // passive homing waiting for event
    logic error;  // last request rejected
    logic done;   // one-cycle pulse on completion
  } ashc_home_stat_t;

endpackage

// ===== rtl/ashc_top.sv
// stop, jog gating and homing control of a two-speed positioning axis
`timescale 1ns/10ps
`default_nettype none
module ashc_top (
  input  wire logic                       core_clk,     // 100 MHz clock
  input  wire logic                       sys_rst,      // async reset, high
  input  wire logic                       nv_init,      // clears retained store
  input  wire logic                       ce,           // clock enable
  input  wire ashc_pkg::ashc_cfg_t        cfg,          // encoder config
  input  wire logic                       stop,         // stop command
  input  wire logic                       jog_pos,      // jog positive level
  input  wire logic                       jog_neg,      // jog negative level
  input  wire logic                       jog_rapid,    // jog at rapid speed
  input  wire logic                       pos_start,    // positioning start
  input  wire ashc_pkg::ashc_drive_t      pos_drive,    // positioning job drive
  input  wire logic                       homing_req,   // homing request
  input  wire logic [1:0]                 reference_method_select, // method
  input  wire logic [ashc_pkg::POS_W-1:0] reference_preset_value,  // preset
  input  wire logic                       reference_digital_input, // ref DI
  input  wire logic                       zero_mark,    // encoder zero mark
  input  wire logic [ashc_pkg::POS_W-1:0] enc_position, // encoder count
  input  wire logic                       enc_error,    // encoder fault
  output ashc_pkg::ashc_drive_t           drive,        // contactor outputs
  output logic                            motion_active,// traversing output on
  output logic [ashc_pkg::POS_W-1:0]      axis_position,// displayed position
  output ashc_pkg::ashc_home_stat_t       home_stat     // homing status
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [ashc_pkg::EDGE_N-1:0] edge_in;
  logic [ashc_pkg::EDGE_N-1:0] rise;
  logic [ashc_pkg::EDGE_N-1:0] fall;

  ashc_pkg::ashc_drive_t      drive_reg;
  ashc_pkg::ashc_drive_t      drive_next;
  ashc_pkg::ashc_home_state_t state_reg;
  ashc_pkg::ashc_home_state_t state_next;

  logic [1:0]                 method_reg;
  logic [ashc_pkg::POS_W-1:0] preset_reg;
  logic [ashc_pkg::POS_W-1:0] inc_offset_reg;
  logic [ashc_pkg::POS_W-1:0] abs_offset;
  logic                       abs_valid;
  logic [ashc_pkg::POS_W-1:0] offset_sel;
  logic [ashc_pkg::POS_W-1:0] new_offset;
  logic [ashc_pkg::POS_W-1:0] axis_pos_reg;
  logic [ashc_pkg::POS_W-1:0] enc_prev_reg;
  logic                       inc_homed_reg;
  logic                       error_reg;
  logic                       done_reg;
  logic                       jog_fwd_reg;
  logic                       jog_rev_reg;

  logic others_idle_home;
  logic others_idle_jogp;
  logic others_idle_jogn;
  logic method_ok;
  logic home_start;
  logic home_accept;
  logic home_reject;
  logic preset_load;
  logic abs_store;
  logic ref_event;
  logic dir_pos;
  logic dir_neg;
  logic passive_hit;
  logic zero_prev_reg;
  logic zero_mark_rise;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  assign edge_in = {reference_digital_input, jog_neg, jog_pos, homing_req};

  ashc_edge_det #(
    .W (ashc_pkg::EDGE_N)
  ) u_edge (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .d        (edge_in),
    .rise     (rise),
    .fall     (fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance

  // an edge counts only with the other jog, homing and positioning start inputs low
  assign others_idle_home = !jog_pos && !jog_neg && !pos_start;
  assign others_idle_jogp = !homing_req && !jog_neg && !pos_start;
  assign others_idle_jogn = !homing_req && !jog_pos && !pos_start;

  // method against encoder kind
  assign method_ok = cfg.abs_encoder ?
                     (reference_method_select == ashc_pkg::METHOD_ABS_ADJ) :
                     (reference_method_select != ashc_pkg::METHOD_ABS_ADJ);

  assign home_start = rise[ashc_pkg::LANE_HOME] && others_idle_home;

  // preset and adjustment need a still axis, passive does not
  always_comb begin
    home_accept = 1'b0;
    if (home_start && method_ok) begin
      unique case (reference_method_select)
        ashc_pkg::METHOD_PRESET:   home_accept = !motion_active;
        ashc_pkg::METHOD_PASS_POS: home_accept = 1'b1;
        ashc_pkg::METHOD_PASS_NEG: home_accept = 1'b1;
        ashc_pkg::METHOD_ABS_ADJ:  home_accept = !motion_active;
      endcase
    end
  end

  assign home_reject = home_start && !home_accept;

  assign preset_load = home_accept &&
                       (reference_method_select == ashc_pkg::METHOD_PRESET);
  assign abs_store   = home_accept &&
                       (reference_method_select == ashc_pkg::METHOD_ABS_ADJ);

  ////////////////////////////////////////////////////////////////////////////
  // reference event and travel direction

  // one configured source
  always_comb begin
    unique case (cfg.ref_source)
      ashc_pkg::SRC_ZERO_MARK: ref_event = zero_mark_rise;
      ashc_pkg::SRC_DI_RISE:   ref_event = rise[ashc_pkg::LANE_DI];
      ashc_pkg::SRC_DI_FALL:   ref_event = fall[ashc_pkg::LANE_DI];
      ashc_pkg::SRC_COMBINED:
        ref_event = zero_mark_rise &&
                    (reference_digital_input == cfg.di_active_hi);
    endcase
  end

  // zero mark edge, kept apart from the command lanes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_prev_reg <= 1'b0;
    end else if (ce) begin
      zero_prev_reg <= zero_mark;
    end
  end
  assign zero_mark_rise = zero_mark && !zero_prev_reg;

  // encoder sample of previous cycle gives the direction
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enc_prev_reg <= ashc_pkg::POS_RST;
    end else if (ce) begin
      enc_prev_reg <= enc_position;
    end
  end
  assign dir_pos = $signed(enc_position) > $signed(enc_prev_reg);
  assign dir_neg = $signed(enc_position) < $signed(enc_prev_reg);

  assign passive_hit = (state_reg == ashc_pkg::HS_ARMED) && ref_event &&
                       ((method_reg == ashc_pkg::METHOD_PASS_POS) ? dir_pos
                                                                  : dir_neg);

  ////////////////////////////////////////////////////////////////////////////
  // homing sequencer

  // arming never touches the drive outputs
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ashc_pkg::HS_IDLE: begin
        if (home_accept &&
            (reference_method_select == ashc_pkg::METHOD_PASS_POS ||
             reference_method_select == ashc_pkg::METHOD_PASS_NEG)) begin
          state_next = ashc_pkg::HS_ARMED;
        end
      end
      ashc_pkg::HS_ARMED: begin
        if (home_accept) begin
          state_next = (reference_method_select == ashc_pkg::METHOD_PASS_POS ||
                        reference_method_select == ashc_pkg::METHOD_PASS_NEG)
                       ? ashc_pkg::HS_ARMED : ashc_pkg::HS_IDLE;
        end else if (passive_hit || enc_error) begin
          state_next = ashc_pkg::HS_IDLE;
        end
      end
      default: state_next = ashc_pkg::HS_IDLE;
    endcase
  end

  // state registered every cycle; method and preset captured at the accepted request edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= ashc_pkg::HS_IDLE;
      method_reg <= ashc_pkg::METHOD_PRESET;
      preset_reg <= ashc_pkg::POS_RST;
    end else if (ce) begin
      state_reg <= state_next;
      if (home_accept) begin
        method_reg <= reference_method_select;
        preset_reg <= reference_preset_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset and position

  // offset that makes the display equal the preset right now
  assign new_offset = (passive_hit ? preset_reg : reference_preset_value)
                      - enc_position;

  // volatile offset for incremental encoders
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inc_offset_reg <= ashc_pkg::OFFSET_RST;
    end else if (ce && (preset_load || passive_hit)) begin
      inc_offset_reg <= new_offset;
    end
  end

  ashc_offset_store u_store (
    .core_clk (core_clk),
    .nv_init  (nv_init),
    .ce       (ce),
    .wr_en    (abs_store),
    .wr_data  (new_offset),
    .rd_data  (abs_offset),
    .rd_valid (abs_valid)
  );

  assign offset_sel = cfg.abs_encoder ? abs_offset : inc_offset_reg;

  // displayed position
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      axis_pos_reg <= ashc_pkg::POS_RST;
    end else if (ce) begin
      axis_pos_reg <= offset_sel + enc_position;
    end
  end
  assign axis_position = axis_pos_reg;

  ////////////////////////////////////////////////////////////////////////////
  // homed, error and done

  // incremental homed, lost at start and on encoder error
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inc_homed_reg <= 1'b0;
    end else if (ce) begin
      if (enc_error) begin
        inc_homed_reg <= 1'b0;
      end else if (preset_load || passive_hit) begin
        inc_homed_reg <= 1'b1;
      end
    end
  end

  // error set on reject, cleared by the next accepted request
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      error_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else if (ce) begin
      if (home_reject) begin
        error_reg <= 1'b1;
      end else if (home_accept) begin
        error_reg <= 1'b0;
      end
      done_reg <= preset_load || abs_store || passive_hit;
    end
  end

  assign home_stat.homed = cfg.abs_encoder ? abs_valid : inc_homed_reg;
  assign home_stat.armed = (state_reg == ashc_pkg::HS_ARMED);
  assign home_stat.error = error_reg;
  assign home_stat.done  = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // jog and drive outputs

  // jog latch: start on clean edge, end on release, both or stop
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      jog_fwd_reg <= 1'b0;
      jog_rev_reg <= 1'b0;
    end else if (ce) begin
      if (stop || !jog_pos || jog_neg) begin
        jog_fwd_reg <= 1'b0;
      end else if (rise[ashc_pkg::LANE_JOGP] && others_idle_jogp) begin
        jog_fwd_reg <= 1'b1;
      end
      if (stop || !jog_neg || jog_pos) begin
        jog_rev_reg <= 1'b0;
      end else if (rise[ashc_pkg::LANE_JOGN] && others_idle_jogn) begin
        jog_rev_reg <= 1'b1;
      end
    end
  end

  // next drive: stop first, then jog, else the positioning job
  always_comb begin
    drive_next = '0;
    if (stop) begin
      drive_next = '0;
    end else if (jog_fwd_reg || jog_rev_reg) begin
      drive_next.pos   = jog_fwd_reg;
      drive_next.neg   = jog_rev_reg;
      drive_next.rapid = jog_rapid;
    end else if (!(pos_drive.pos && pos_drive.neg)) begin
      drive_next = pos_drive;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_reg <= '0;
    end else if (ce) begin
      drive_reg <= drive_next;
    end
  end

  // stop gates the contactors without waiting for a clock edge
  assign drive         = stop ? '0 : drive_reg;
  assign motion_active = drive_reg.pos || drive_reg.neg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_stop_off;
    @(posedge core_clk) disable iff (sys_rst)
      stop |-> (drive == '0);
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("drive active during stop");
  property p_stop_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (stop && ce) ##1 stop |-> !motion_active;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("motion restarted under stop");
  property p_stop_first;
    @(posedge core_clk) disable iff (sys_rst)
      (ce && stop) |=> !drive_reg.pos && !drive_reg.neg;
  endproperty
  a_stop_first: assert property (p_stop_first)
    else $error("stop did not clear drive state");
  property p_preset_pos;
    @(posedge core_clk) disable iff (sys_rst)
      (ce && preset_load && !cfg.abs_encoder) ##1 ce
        |=> axis_position == $past(reference_preset_value, 2)
                             - $past(enc_position, 2) + $past(enc_position);
  endproperty
  a_preset_pos: assert property (p_preset_pos)
    else $error("preset not shown in position");
  property p_homed_set;
    @(posedge core_clk) disable iff (sys_rst)
      (ce && preset_load && !enc_error) |=> inc_homed_reg && done_reg;
  endproperty
  a_homed_set: assert property (p_homed_set)
    else $error("homed not set after preset");
  property p_reject;
    @(posedge core_clk) disable iff (sys_rst)
      (ce && home_reject) |=> error_reg &&
        inc_offset_reg == $past(inc_offset_reg) && !done_reg;
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected request changed state");
  property p_arm_nodrive;
    @(posedge core_clk) disable iff (sys_rst)
      (ce && home_stat.armed && !jog_fwd_reg && !jog_rev_reg &&
       pos_drive == '0 && !motion_active) |=> !motion_active;
  endproperty
  a_arm_nodrive: assert property (p_arm_nodrive)
    else $error("armed homing moved the axis");
  property p_enc_err;
    @(posedge core_clk) disable iff (sys_rst)
      (ce && enc_error) |=> !inc_homed_reg;
  endproperty
  a_enc_err: assert property (p_enc_err)
    else $error("homed kept after encoder error");
  property p_method;
    @(posedge core_clk) disable iff (sys_rst)
      (home_start && cfg.abs_encoder &&
       reference_method_select != ashc_pkg::METHOD_ABS_ADJ) |-> home_reject;
  endproperty
  a_method: assert property (p_method)
    else $error("wrong method accepted");

endmodule
`default_nettype wire

// ===== testbench/ashc_enc_model.sv
// encoder counter and contactor stand-in for the axis block
`timescale 1ns/10ps
`default_nettype none
module ashc_enc_model #(
  parameter logic [31:0] START = 32'h0000_0100 // arbitrary start count
) (
  input  wire logic                  core_clk,     // clock
  input  wire ashc_pkg::ashc_drive_t drive,        // contactor outputs
  output logic [31:0]                enc_position, // encoder count
  output logic                       zero_mark     // encoder zero mark
);
  logic [31:0] step;

  // rapid moves four counts a cycle, creep one
  assign step = drive.rapid ? 32'h0000_0004 : 32'h0000_0001;

  // count follows the contactors, no reset: the shaft keeps its place
  initial enc_position = START;
  always @(posedge core_clk) begin
    if (drive.pos && !drive.neg) begin
      enc_position <= enc_position + step;
    end else if (drive.neg && !drive.pos) begin
      enc_position <= enc_position - step;
    end
  end

  // mark spans four counts once per sixteen, so rapid cannot skip it
  assign zero_mark = (enc_position[3:2] == 2'h2);
endmodule
`default_nettype wire

// ===== testbench/ashc_top_tb.sv
// self-checking bench for the axis stop and homing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module ashc_top_tb;
  logic                      core_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      nv_init = 1'b1;
  logic                      ce = 1'b1;
  ashc_pkg::ashc_cfg_t       cfg = 4'h1;
  logic                      stop = 1'b0;
  logic                      jog_pos = 1'b0;
  logic                      jog_neg = 1'b0;
  logic                      jog_rapid = 1'b0;
  logic                      pos_start = 1'b0;
  ashc_pkg::ashc_drive_t     pos_drive = 3'h0;
  logic                      homing_req = 1'b0;
  logic [1:0]                reference_method_select = 2'h0;
  logic [31:0]               reference_preset_value = 32'h0;
  logic                      reference_digital_input = 1'b0;
  logic                      enc_error = 1'b0;
  logic                      zero_mark;
  logic [31:0]               enc_position;
  ashc_pkg::ashc_drive_t     drive;
  logic                      motion_active;
  logic [31:0]               axis_position;
  ashc_pkg::ashc_home_stat_t home_stat;
  logic                      ok;
  logic [31:0]               e0;
  int                        hits;
  int                        err_count = 0;
  int                        num_checks = 0;

  // clock and instances
  always #5 core_clk = ~core_clk;
  ashc_top u_ashc_top (.core_clk, .sys_rst, .nv_init, .ce, .cfg, .stop,
    .jog_pos, .jog_neg, .jog_rapid, .pos_start, .pos_drive, .homing_req,
    .reference_method_select, .reference_preset_value,
    .reference_digital_input, .zero_mark, .enc_position, .enc_error,
    .drive, .motion_active, .axis_position, .home_stat);
  ashc_enc_model u_ashc_enc_model (.core_clk, .drive, .enc_position,
    .zero_mark);

  ////////////////////////////////////////////////////////////////////////
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one request edge; ok tells whether done answered
  task automatic home(input logic [1:0] m, input logic [31:0] p,
                      output logic ok);
    reference_method_select = m;
    reference_preset_value = p;
    homing_req = 1'b1;
    tick(1);
    ok = home_stat.done;
    homing_req = 1'b0;
    tick(1);
  endtask

  // counts done pulses over a fixed span
  task automatic watch(input int n, output int hits);
    hits = 0;
    repeat (n) begin
      tick(1);
      if (home_stat.done === 1'b1) hits++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(2);
    nv_init = 1'b0;
    tick(6);
    sys_rst = 1'b0;
    tick(2);
    `CHK("reset homed", 1'b0, home_stat.homed)
    // stop cuts a jog and blocks restarts
    jog_pos = 1'b1;
    jog_rapid = 1'b1;
    tick(3);
    `CHK("jog drive", 3'h5, drive)
    stop = 1'b1;
    #1;
    `CHK("stop drive", 3'h0, drive)
    tick(1);
    jog_pos = 1'b0;
    jog_rapid = 1'b0;
    tick(2);
    jog_pos = 1'b1;
    pos_drive = 3'h4;
    tick(3);
    `CHK("stop hold", 3'h0, drive)
    `CHK("stop motion", 1'b0, motion_active)
    jog_pos = 1'b0;
    pos_drive = 3'h0;
    stop = 1'b0;
    tick(2);
    // direct preset, twice, then two rejected requests
    home(ashc_pkg::METHOD_PRESET, 32'h0000_1234, ok);
    `CHK("preset done", 1'b1, ok)
    `CHK("preset pos", 32'h0000_1234, axis_position)
    home(ashc_pkg::METHOD_PRESET, 32'hffff_fff0, ok);
    e0 = enc_position;
    `CHK("rehomed", 1'b1, home_stat.homed)
    `CHK("preset pos2", 32'hffff_fff0, axis_position)
    home(ashc_pkg::METHOD_ABS_ADJ, 32'h0000_0001, ok);
    `CHK("abs on incr", 1'b1, home_stat.error)
    pos_drive = 3'h4;
    tick(2);
    home(ashc_pkg::METHOD_PRESET, 32'h0000_0777, ok);
    `CHK("preset moving", 1'b0, ok)
    pos_drive = 3'h0;
    tick(2);
    `CHK("pos kept", 32'hffff_fff0 + enc_position - e0, axis_position)
    // passive homing both ways, wrong way first
    for (int m = 1; m < 3; m++) begin
      home(2'(m), 32'h0000_5000, ok);
      `CHK("armed", 1'b1, home_stat.armed)
      tick(4);
      `CHK("arm idle", 3'h0, drive)
      pos_drive = (m == 1) ? 3'h2 : 3'h4;
      watch(40, hits);
      `CHK("wrong way", 0, hits)
      pos_drive = (m == 1) ? 3'h4 : 3'h2;
      watch(40, hits);
      `CHK("ref event", 1, hits)
      pos_drive = 3'h0;
      tick(2);
    end
    // an edge with another command high is ignored
    pos_start = 1'b1;
    home(ashc_pkg::METHOD_PRESET, 32'h0000_0001, ok);
    `CHK("busy done", 1'b0, ok)
    `CHK("busy error", 1'b0, home_stat.error)
    pos_start = 1'b0;
    // combined source, then a falling input edge while moving
    cfg.ref_source = ashc_pkg::SRC_COMBINED;
    home(ashc_pkg::METHOD_PASS_POS, 32'h0000_6000, ok);
    pos_drive = 3'h4;
    watch(40, hits);
    `CHK("gated mark", 0, hits)
    reference_digital_input = 1'b1;
    watch(40, hits);
    `CHK("combined", 1, hits)
    cfg.ref_source = ashc_pkg::SRC_DI_FALL;
    home(ashc_pkg::METHOD_PASS_POS, 32'h0000_7000, ok);
    reference_digital_input = 1'b0;
    watch(4, hits);
    `CHK("di fall", 1, hits)
    pos_drive = 3'h0;
    tick(2);
    enc_error = 1'b1;
    tick(1);
    enc_error = 1'b0;
    tick(1);
    `CHK("enc error", 1'b0, home_stat.homed)
    // absolute encoder adjustment and retention
    sys_rst = 1'b1;
    cfg.abs_encoder = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(2);
    home(ashc_pkg::METHOD_ABS_ADJ, 32'h0000_abcd, ok);
    `CHK("abs done", 1'b1, ok)
    tick(1);
    `CHK("abs pos", 32'h0000_abcd, axis_position)
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(2);
    `CHK("kept homed", 1'b1, home_stat.homed)
    `CHK("kept pos", 32'h0000_abcd, axis_position)
    home(ashc_pkg::METHOD_PRESET, 32'h0000_0001, ok);
    `CHK("preset on abs", 1'b0, ok)
    pos_drive = 3'h4;
    tick(2);
    home(ashc_pkg::METHOD_ABS_ADJ, 32'h0000_0002, ok);
    `CHK("abs moving", 1'b0, ok)
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
